// [src/start_pattern_detect_config.sv]
// Start-pattern detector with its APB register file and payload output.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "start_pattern_cfg.svh"
//
// What this block does
// [R01] Resync off in gap mode: gap is coarse plus fine, sixteenth-bit steps.
// [R02] Resync on: PLL resync after gap, coarse half bits only, fine ignored.
// [R03] Wildcard bits mask the four lowest chips of pattern A.
// [R04] Readjust off: polarity from matched pattern; on: realign phase in payload.
// [R05] Mode 00: A then B as one identifier, B only if A=16, B>0.
// [R06] Mode 01: A or B matching in parallel starts the telegram.
// [R07] Mode 10: A, then the configured gap, then B.
// [R08] Mode 11: A or B; first data bit is 0 for A, 1 for B.
// [R09] A length is 1 to 16 chips; larger codes are unused.
// [R10] Software avoids very short A lengths; phase becomes unreliable.
// [R11] B length zero only in mode 00; at most 16 chips always.
// [R12] Gap mode: coarse gap locks PLL; fine gap corrects phase without resync.
// [R13] Each pattern is two bytes: chips 7..0 low, chips 15..8 high.
// [R14] Software adds one to payload length in extended mode.
// [R15] After detection pass payload bits; correlators idle until a new start.
module start_pattern_detect_config (
	input  wire logic        pclk,          // Clock, 100 MHz.
	input  wire logic        presetn,       // Asynchronous reset, active low.
	input  wire logic        psel,          // APB select.
	input  wire logic        penable,       // APB access phase.
	input  wire logic        pwrite,        // APB write.
	input  wire logic [11:0] paddr,         // APB byte address.
	input  wire logic [31:0] pwdata,        // APB write data.
	output      logic [31:0] prdata,        // APB read data.
	output      logic        pready,        // APB ready.
	output      logic        pslverr,       // APB error, unmapped address.
	input  wire logic        chip_valid,    // A chip arrives.
	input  wire logic        chip_data,     // Chip value.
	input  wire logic        sample_tick,   // Sixteenth-bit tick.
	output      logic        payload_valid, // Payload bit strobe.
	output      logic        payload_bit,   // Payload bit.
	output      logic        code_polarity, // Polarity applied to payload.
	output      logic        phase_readjust,// Phase readjust is active.
	output      logic        pll_resync,    // Resync PLL after the gap.
	output      logic        dco_fix_valid, // Apply fine phase correction.
	output      logic [2:0]  dco_fix_val,   // Fine correction, sixteenths.
	output      logic        start_found    // Start pattern detected.
);
	start_pattern_pkg::detect_state_e state;
	start_pattern_pkg::detect_state_e next_state;
	start_pattern_pkg::detect_mode_e  det_mode;
	logic [7:0]  start_detect_mode;
	logic [4:0]  pattern_a_chips;
	logic [4:0]  pattern_b_chips;
	logic [7:0]  gap_cfg;
	logic [15:0] pat_a;
	logic [15:0] pat_b;
	logic [15:0] hist;
	logic [4:0]  cnt;
	logic [4:0]  next_cnt;
	logic        matched_b;
	logic        pair_phase;
	logic        first_chip;
	logic        detect;
	logic        gap_start;
	logic        gap_done;
	logic        hit_a;
	logic        hit_b;
	logic [31:0] rd_word;

	wire [9:0]  idx;
	wire        setup;
	wire        access;
	wire        mapped;
	wire        wr;
	wire        start_cmd;
	wire        stop_cmd;
	wire [15:0] hist_next;
	wire [4:0]  cnt_inc;
	wire        par_mode;
	wire        seq_b_used;
	wire        lenb_ok;
	wire        b_done;
	wire        resync;
	wire        readjust;
	wire        busy;
	wire        take_chip;
	wire        emit;

	// APB slave: zero wait states, read data captured in the setup phase.
	assign idx     = paddr[11:2];
	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign mapped  = (idx >= `IDX_MODE && idx <= `IDX_PAT_B1) ||
		idx == `IDX_CTRL || idx == `IDX_STAT;
	assign wr      = access && pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;
	assign start_cmd = wr && idx == `IDX_CTRL && pwdata[`CTRL_START];
	assign stop_cmd  = wr && idx == `IDX_CTRL && pwdata[`CTRL_STOP];

	always_comb begin
		rd_word = 32'h0000_0000;
		if (idx == `IDX_MODE) begin
			rd_word[7:0] = start_detect_mode;
		end else if (idx == `IDX_LEN_A) begin
			rd_word[4:0] = pattern_a_chips;
		end else if (idx == `IDX_LEN_B) begin
			rd_word[4:0] = pattern_b_chips;
		end else if (idx == `IDX_GAP) begin
			rd_word[7:0] = gap_cfg;
		end else if (idx == `IDX_PAT_A0) begin
			rd_word[7:0] = pat_a[7:0];
		end else if (idx == `IDX_PAT_A1) begin
			rd_word[7:0] = pat_a[15:8];
		end else if (idx == `IDX_PAT_B0) begin
			rd_word[7:0] = pat_b[7:0];
		end else if (idx == `IDX_PAT_B1) begin
			rd_word[7:0] = pat_b[15:8];
		end else if (idx == `IDX_STAT) begin
			rd_word[5:0] = {state, matched_b, start_found, busy};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_detect_mode <= `RST_MODE;
			pattern_a_chips   <= `RST_LEN;
			pattern_b_chips   <= `RST_LEN;
			gap_cfg           <= `RST_BYTE;
			pat_a             <= {`RST_BYTE, `RST_BYTE};
			pat_b             <= {`RST_BYTE, `RST_BYTE};
		end else if (wr) begin
			if (idx == `IDX_MODE) start_detect_mode <= pwdata[7:0];
			if (idx == `IDX_LEN_A) pattern_a_chips <= pwdata[`LEN_HI:0];
			if (idx == `IDX_LEN_B) pattern_b_chips <= pwdata[`LEN_HI:0];
			if (idx == `IDX_GAP) gap_cfg <= pwdata[7:0];
			if (idx == `IDX_PAT_A0) pat_a[7:0] <= pwdata[7:0];  // [R13]
			if (idx == `IDX_PAT_A1) pat_a[15:8] <= pwdata[7:0]; // [R13]
			if (idx == `IDX_PAT_B0) pat_b[7:0] <= pwdata[7:0];  // [R13]
			if (idx == `IDX_PAT_B1) pat_b[15:8] <= pwdata[7:0]; // [R13]
		end
	end

	// Mode fields and the correlators.
	assign det_mode   = start_pattern_pkg::detect_mode_e'(
		start_detect_mode[`MODE_DET_HI:`MODE_DET_LO]);
	assign resync     = start_detect_mode[`MODE_RESYNC];
	assign readjust   = start_detect_mode[`MODE_READJ];
	assign phase_readjust = readjust;
	assign hist_next  = {hist[14:0], chip_data};
	assign cnt_inc    = cnt + 5'h01;
	assign par_mode   = det_mode == start_pattern_pkg::DET_PARALLEL ||
		det_mode == start_pattern_pkg::DET_EXTENDED;
	assign seq_b_used = pattern_a_chips == `MAX_CHIPS &&
		pattern_b_chips != 5'h00; // [R05]
	assign lenb_ok    = pattern_b_chips != 5'h00 &&
		pattern_b_chips <= `MAX_CHIPS; // [R11]
	assign b_done     = cnt_inc == pattern_b_chips || !lenb_ok;
	assign busy       = state != start_pattern_pkg::ST_IDLE &&
		state != start_pattern_pkg::ST_PAYLOAD;

	pattern_correlator #(.CHIPS(16)) u_corr_a (
		.hist    (hist_next),
		.pattern (pat_a),
		.len     (pattern_a_chips),
		.wild    (start_detect_mode[`MODE_WC_HI:`MODE_WC_LO]), // [R03]
		.hit     (hit_a)
	);

	pattern_correlator #(.CHIPS(16)) u_corr_b (
		.hist    (hist_next),
		.pattern (pat_b),
		.len     (pattern_b_chips),
		.wild    (4'h0),
		.hit     (hit_b)
	);

	gap_timer u_gap (
		.pclk        (pclk),
		.presetn     (presetn),
		.start       (gap_start),
		.resync      (resync),                                     // [R01]
		.coarse      (gap_cfg[`GAP_COARSE_HI:`GAP_COARSE_LO]),     // [R02]
		.fine        (gap_cfg[`GAP_FINE_HI:`GAP_FINE_LO]),
		.sample_tick (sample_tick),
		.done        (gap_done)
	);

	// Search sequencer; a detection wins over a command in the same cycle.
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		detect     = 1'b0;
		gap_start  = 1'b0;
		case (state)
			start_pattern_pkg::ST_SEARCH: begin
				if (chip_valid && par_mode && (hit_a || hit_b)) begin
					detect = 1'b1; // [R06] [R08]
				end else if (chip_valid && hit_a) begin
					next_cnt = 5'h00;
					if (det_mode == start_pattern_pkg::DET_GAP) begin
						next_state = start_pattern_pkg::ST_GAP; // [R07]
						gap_start  = 1'b1;
					end else if (seq_b_used) begin
						next_state = start_pattern_pkg::ST_SEQ_B; // [R05]
					end else begin
						detect = 1'b1; // [R05]
					end
				end
			end
			start_pattern_pkg::ST_GAP: begin
				if (gap_done) begin
					next_state = start_pattern_pkg::ST_GAP_B; // [R07]
					next_cnt   = 5'h00;
				end
			end
			start_pattern_pkg::ST_SEQ_B, start_pattern_pkg::ST_GAP_B: begin
				if (chip_valid) begin
					next_cnt = cnt_inc;
					if (b_done && hit_b) begin
						detect = 1'b1; // [R05] [R07]
					end else if (b_done) begin
						next_state = start_pattern_pkg::ST_SEARCH;
					end
				end
			end
			default: begin
			end
		endcase
		if (detect) begin
			next_state = start_pattern_pkg::ST_PAYLOAD; // [R15]
		end else if (start_cmd) begin
			next_state = start_pattern_pkg::ST_SEARCH;
		end else if (stop_cmd) begin
			next_state = start_pattern_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= start_pattern_pkg::ST_IDLE;
			cnt   <= 5'h00;
			hist  <= 16'h0000;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			if (chip_valid && busy) hist <= hist_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_found   <= 1'b0;
			matched_b     <= 1'b0;
			code_polarity <= 1'b0;
		end else if (detect) begin
			start_found   <= 1'b1;
			matched_b     <= state != start_pattern_pkg::ST_SEARCH || !hit_a;
			code_polarity <= !readjust && (hit_a &&
				state == start_pattern_pkg::ST_SEARCH ? pat_a[0] : pat_b[0]); // [R04]
		end else if (start_cmd) begin
			start_found   <= 1'b0;
		end
	end

	// Payload: chip pairs become bits; readjust drops a chip on a bad pair.
	assign take_chip = chip_valid && state == start_pattern_pkg::ST_PAYLOAD;
	assign emit = take_chip && pair_phase &&
		!(readjust && chip_data == first_chip); // [R04]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			payload_valid <= 1'b0;
			payload_bit   <= 1'b0;
			pair_phase    <= 1'b0;
			first_chip    <= 1'b0;
		end else if (detect) begin
			payload_valid <= det_mode == start_pattern_pkg::DET_EXTENDED; // [R08]
			payload_bit   <= !hit_a;
			pair_phase    <= 1'b0;
		end else begin
			payload_valid <= emit; // [R15]
			if (emit) payload_bit <= first_chip ^ code_polarity;
			if (take_chip && !emit) first_chip <= chip_data;
			if (take_chip) pair_phase <= !emit;
		end
	end

	// Gap end: resync the PLL, or apply the fine phase correction.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_resync    <= 1'b0;
			dco_fix_valid <= 1'b0;
			dco_fix_val   <= 3'h0;
		end else begin
			pll_resync    <= gap_done && resync;  // [R02] [R12]
			dco_fix_valid <= gap_done && !resync; // [R01] [R12]
			dco_fix_val   <= gap_cfg[`GAP_FINE_HI:`GAP_FINE_LO];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_par_detect: assert property (state == start_pattern_pkg::ST_SEARCH && // [R06]
		chip_valid && det_mode == start_pattern_pkg::DET_PARALLEL &&
		(hit_a || hit_b) |=> state == start_pattern_pkg::ST_PAYLOAD && start_found)
		else $error("parallel match did not start payload");
	a_seq_b_entry: assert property (state == start_pattern_pkg::ST_SEARCH && // [R05]
		chip_valid && det_mode == start_pattern_pkg::DET_SEQ16 && hit_a &&
		seq_b_used && !start_cmd && !stop_cmd |=>
		state == start_pattern_pkg::ST_SEQ_B)
		else $error("sequential mode skipped pattern B");
	a_seq_a_only: assert property (state == start_pattern_pkg::ST_SEARCH && // [R05]
		chip_valid && det_mode == start_pattern_pkg::DET_SEQ16 && hit_a &&
		pattern_a_chips != `MAX_CHIPS |=> state == start_pattern_pkg::ST_PAYLOAD)
		else $error("short pattern A did not detect alone");
	a_gap_entry: assert property (state == start_pattern_pkg::ST_SEARCH && // [R07]
		chip_valid && det_mode == start_pattern_pkg::DET_GAP && hit_a &&
		!start_cmd && !stop_cmd |=> state == start_pattern_pkg::ST_GAP)
		else $error("gap mode did not wait for the gap");
	a_gap_order: assert property ($rose(start_found) && // [R07]
		det_mode == start_pattern_pkg::DET_GAP |->
		$past(state) == start_pattern_pkg::ST_GAP_B)
		else $error("gap mode detected without pattern B");
	a_ext_ind: assert property (state == start_pattern_pkg::ST_SEARCH && // [R08]
		chip_valid && det_mode == start_pattern_pkg::DET_EXTENDED &&
		(hit_a || hit_b) |=> payload_valid && payload_bit == !$past(hit_a))
		else $error("indicator bit wrong in extended mode");
	a_resync: assert property (gap_done && resync |=> // [R02]
		pll_resync && !dco_fix_valid)
		else $error("no PLL resync after the gap");
	a_fine_fix: assert property (gap_done && !resync |=> dco_fix_valid && // [R01] [R12]
		dco_fix_val == $past(gap_cfg[`GAP_FINE_HI:`GAP_FINE_LO]))
		else $error("fine gap correction missing");
	a_wild_a: assert property (state == start_pattern_pkg::ST_SEARCH && // [R03]
		chip_valid && pattern_a_chips == 5'h04 && start_detect_mode[6:3] == 4'hF
		|-> hit_a)
		else $error("wildcards did not mask pattern A");
	a_len_range: assert property (pattern_a_chips > `MAX_CHIPS || // [R09] [R11]
		pattern_a_chips == 5'h00 |-> !hit_a)
		else $error("invalid pattern length matched");
	a_polarity: assert property (detect && !readjust && !hit_a && // [R04]
		state == start_pattern_pkg::ST_SEARCH |=> code_polarity == $past(pat_b[0]))
		else $error("polarity not taken from pattern B");
	a_pay_hold: assert property (state == start_pattern_pkg::ST_PAYLOAD && // [R15]
		!start_cmd && !stop_cmd |=> state == start_pattern_pkg::ST_PAYLOAD &&
		!pll_resync)
		else $error("payload left without a command");
	a_pat_bytes: assert property (wr && idx == `IDX_PAT_A1 |=> // [R13]
		pat_a[15:8] == $past(pwdata[7:0]) && $stable(pat_a[7:0]))
		else $error("pattern high byte misplaced");

	c_par: cover property (state == start_pattern_pkg::ST_SEARCH &&
		det_mode == start_pattern_pkg::DET_PARALLEL && detect);
	c_seq16: cover property (state == start_pattern_pkg::ST_SEQ_B && detect);
	c_gap: cover property (state == start_pattern_pkg::ST_GAP_B && detect);
	c_ext_b: cover property (detect && !hit_a &&
		det_mode == start_pattern_pkg::DET_EXTENDED);
endmodule : start_pattern_detect_config

// [src/start_pattern_cfg.svh]
// Register indices, field positions and reset values of the start-pattern detector.
`ifndef START_PATTERN_CFG_SVH
`define START_PATTERN_CFG_SVH
`define IDX_MODE      10'h04D
`define IDX_LEN_A     10'h04E
`define IDX_LEN_B     10'h04F
`define IDX_GAP       10'h050
`define IDX_PAT_A0    10'h051
`define IDX_PAT_A1    10'h052
`define IDX_PAT_B0    10'h053
`define IDX_PAT_B1    10'h054
`define IDX_CTRL      10'h060
`define IDX_STAT      10'h061
`define MODE_RESYNC   7
`define MODE_WC_HI    6
`define MODE_WC_LO    3
`define MODE_READJ    2
`define MODE_DET_HI   1
`define MODE_DET_LO   0
`define LEN_HI        4
`define GAP_COARSE_HI 7
`define GAP_COARSE_LO 3
`define GAP_FINE_HI   2
`define GAP_FINE_LO   0
`define CTRL_START    0
`define CTRL_STOP     1
`define RST_MODE      8'h80
`define RST_LEN       5'h00
`define RST_BYTE      8'h00
`define MAX_CHIPS     5'h10
`endif

// [src/start_pattern_pkg.sv]
// Types shared by the start-pattern detector files.
package start_pattern_pkg;
	typedef enum logic [1:0] {
		DET_SEQ16    = 2'b00,
		DET_PARALLEL = 2'b01,
		DET_GAP      = 2'b10,
		DET_EXTENDED = 2'b11
	} detect_mode_e;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_SEARCH  = 3'b001,
		ST_SEQ_B   = 3'b010,
		ST_GAP     = 3'b011,
		ST_GAP_B   = 3'b100,
		ST_PAYLOAD = 3'b101
	} detect_state_e;
endpackage : start_pattern_pkg

// [src/pattern_correlator.sv]
// Masked comparison of the newest received chips against a reference pattern.
`timescale 1ns/1ps
module pattern_correlator #(
	parameter int CHIPS = 16
) (
	input  wire logic [CHIPS-1:0] hist,    // Received chips, newest in bit 0.
	input  wire logic [CHIPS-1:0] pattern, // Reference chips, chip 0 newest.
	input  wire logic [4:0]       len,     // Chips compared.
	input  wire logic [3:0]       wild,    // Ignore masks for chips 3..0.
	output      logic             hit      // Pattern matches.
);
	logic [CHIPS-1:0] care;
	wire              len_ok;

	// Lengths of zero or beyond the pattern width never match.
	assign len_ok = (len != 5'h00) && (len <= 5'(CHIPS)); // [R09]

	genvar i;
	generate
		for (i = 0; i < CHIPS; i++) begin : g_care
			if (i < 4) begin : g_wild
				assign care[i] = (5'(i) < len) && !wild[i];
			end else begin : g_plain
				assign care[i] = 5'(i) < len;
			end
		end
	endgenerate

	assign hit = len_ok && (((hist ^ pattern) & care) == '0);
endmodule : pattern_correlator

// [src/gap_timer.sv]
// Counts the gap between the two patterns in sixteenth-bit sample ticks.
`timescale 1ns/1ps
module gap_timer (
	input  wire logic       pclk,        // Clock.
	input  wire logic       presetn,     // Asynchronous reset, active low.
	input  wire logic       start,       // Load and start the gap.
	input  wire logic       resync,      // Half-bit resolution only.
	input  wire logic [4:0] coarse,      // Gap in half bits.
	input  wire logic [2:0] fine,        // Extra gap in sixteenth bits.
	input  wire logic       sample_tick, // One pulse per sixteenth bit.
	output      logic       done         // Gap elapsed, one cycle.
);
	logic [7:0] cnt;
	logic       run;
	wire  [7:0] load;

	assign load = resync ? {coarse, 3'h0} : {coarse, 3'h0} + {5'h00, fine};
	assign done = run && (cnt == 8'h00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			run <= 1'b0;
		end else if (start) begin
			cnt <= load;
			run <= 1'b1;
		end else if (done) begin
			run <= 1'b0;
		end else if (run && sample_tick) begin
			cnt <= cnt - 8'h01;
		end
	end

	a_gap_load: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> run && cnt == $past(load)) // [R01] [R02]
		else $error("gap timer loaded a wrong length");
endmodule : gap_timer

// [tb/chip_source.sv]
// Chip stream source that stands in for the slicer and clock recovery.
`timescale 1ns/1ps
module chip_source (
	input  wire logic pclk,        // Clock.
	output      logic chip_valid,  // Chip strobe.
	output      logic chip_data,   // Chip value.
	output      logic sample_tick  // Sixteenth-bit tick.
);
	int spacing = 0;

	initial begin
		chip_valid = 1'b0;
		chip_data = 1'b0;
		// A tick on every cycle makes a gap last exactly its tick count.
		sample_tick = 1'b1;
	end

	// Chips go out oldest first, so chip 0 of a pattern arrives last.
	task automatic send(input logic [15:0] chips, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			repeat (spacing) @(posedge pclk);
			@(posedge pclk);
			chip_valid <= 1'b1;
			chip_data  <= chips[i];
			@(posedge pclk);
			chip_valid <= 1'b0;
			// The line does not keep the last chip between strobes.
			chip_data  <= ~chips[i];
		end
	endtask : send
endmodule : chip_source

// [tb/tb.sv]
// Self-checking bench for the start-pattern detector.
`timescale 1ns/1ps
`include "start_pattern_cfg.svh"
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        chip_valid, chip_data, sample_tick, err;
	logic        payload_valid, payload_bit, code_polarity, phase_readjust;
	logic        pll_resync, dco_fix_valid, start_found;
	logic [2:0]  dco_fix_val;
	int          fail_count = 0;
	int          num_checks = 0;
	int          t_on, t_off;

	start_pattern_detect_config u_start_pattern_detect_config (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chip_valid(chip_valid),
		.chip_data(chip_data), .sample_tick(sample_tick),
		.payload_valid(payload_valid), .payload_bit(payload_bit),
		.code_polarity(code_polarity), .phase_readjust(phase_readjust),
		.pll_resync(pll_resync), .dco_fix_valid(dco_fix_valid),
		.dco_fix_val(dco_fix_val), .start_found(start_found));

	chip_source u_chip_source (
		.pclk(pclk), .chip_valid(chip_valid), .chip_data(chip_data),
		.sample_tick(sample_tick));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t %s got %0h", $time, what, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [9:0] idx,
			input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic cfg(input logic [7:0] mode, input logic [4:0] la, lb,
			input logic [15:0] pa, pb);
		apb(1'b1, `IDX_MODE, {24'h0, mode});
		apb(1'b1, `IDX_LEN_A, {27'h0, la});
		apb(1'b1, `IDX_LEN_B, {27'h0, lb});
		apb(1'b1, `IDX_PAT_A0, {24'h0, pa[7:0]});
		apb(1'b1, `IDX_PAT_A1, {24'h0, pa[15:8]});
		apb(1'b1, `IDX_PAT_B0, {24'h0, pb[7:0]});
		apb(1'b1, `IDX_PAT_B1, {24'h0, pb[15:8]});
		apb(1'b1, `IDX_CTRL, 32'h1);
	endtask : cfg

	task automatic found(input logic exp, input string what);
		@(posedge pclk);
		#1;
		chk({31'h0, start_found}, {31'h0, exp}, what);
	endtask : found

	task automatic t_regs();
		apb(1'b0, `IDX_MODE, 32'h0);
		chk(rd, {24'h0, `RST_MODE}, "mode reset");
		apb(1'b0, `IDX_LEN_B, 32'h0);
		chk(rd, 32'h0, "length b reset");
		apb(1'b1, `IDX_LEN_A, 32'hFF);
		apb(1'b0, `IDX_LEN_A, 32'h0);
		chk(rd, 32'h1F, "length a field");
		apb(1'b0, 10'h3FF, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		apb(1'b1, `IDX_CTRL, 32'h1);
		apb(1'b0, `IDX_STAT, 32'h0);
		chk(rd, 32'h09, "search started");
		apb(1'b1, `IDX_CTRL, 32'h2);
		apb(1'b0, `IDX_STAT, 32'h0);
		chk(rd, 32'h00, "search stopped");
		apb(1'b1, `IDX_MODE, 32'h84);
		// The mode register updates in the NBA region of the access edge.
		#1;
		chk({31'h0, phase_readjust}, 32'h1, "readjust level");
	endtask : t_regs

	task automatic t_parallel();
		cfg(8'h01, 5'h08, 5'h08, 16'h00A5, 16'h003C);
		u_chip_source.send(16'h00AA, 8);
		found(1'b0, "mismatch without wildcards");
		cfg(8'h79, 5'h08, 5'h08, 16'h00A5, 16'h003C);
		u_chip_source.send(16'h00AA, 8);
		found(1'b1, "wildcard match");
		cfg(8'h01, 5'h08, 5'h08, 16'h00A5, 16'h003C);
		u_chip_source.send(16'h003C, 8);
		found(1'b1, "parallel b match");
		apb(1'b0, `IDX_STAT, 32'h0);
		chk({31'h0, rd[2]}, 32'h1, "matched b");
	endtask : t_parallel

	task automatic t_extended();
		for (int k = 0; k < 2; k++) begin
			cfg(8'h03, 5'h08, 5'h08, 16'h00A5, 16'h003C);
			u_chip_source.send(k ? 16'h003C : 16'h00A5, 8);
			#1;
			chk({31'h0, payload_valid}, 32'h1, "indicator strobe");
			chk({31'h0, payload_bit}, k, "indicator bit");
		end
	endtask : t_extended

	task automatic t_seq16();
		cfg(8'h00, 5'h10, 5'h08, 16'hA5C3, 16'h0096);
		u_chip_source.send(16'hA5C3, 16);
		u_chip_source.send(16'h0069, 8);
		found(1'b0, "wrong second part");
		u_chip_source.send(16'hA5C3, 16);
		u_chip_source.send(16'h0096, 8);
		found(1'b1, "identifier match");
		cfg(8'h00, 5'h10, 5'h00, 16'hA5C3, 16'h0096);
		u_chip_source.send(16'hA5C3, 16);
		found(1'b1, "first part alone");
	endtask : t_seq16

	task automatic t_gap(input logic rs, output int cyc);
		apb(1'b1, `IDX_GAP, 32'h0B);
		cfg({rs, 7'h02}, 5'h08, 5'h08, 16'h00A5, 16'h003C);
		u_chip_source.send(16'h00A5, 8);
		cyc = 0;
		do begin
			@(posedge pclk);
			#1;
			cyc++;
		end while (pll_resync !== 1'b1 && dco_fix_valid !== 1'b1 && cyc < 300);
		chk({31'h0, pll_resync}, {31'h0, rs}, "resync pulse");
		chk({31'h0, dco_fix_valid}, {31'h0, ~rs}, "fine fix");
		if (!rs)
			chk({29'h0, dco_fix_val}, 32'h3, "fine value");
		u_chip_source.send(16'h003C, 8);
		found(1'b1, "gap mode match");
	endtask : t_gap

	task automatic t_payload(input logic ro);
		u_chip_source.spacing = ro ? 3 : 0;
		cfg({5'h00, ro, 2'b01}, 5'h08, 5'h08, 16'h00A5, 16'h003C);
		u_chip_source.send(16'h00A5, 8);
		found(1'b1, "payload start");
		chk({31'h0, code_polarity}, {31'h0, ~ro}, "polarity");
		// With readjust on, the repeated first chip is dropped before the pair.
		u_chip_source.send(ro ? 16'h0006 : 16'h0002, ro ? 3 : 2);
		#1;
		chk({31'h0, payload_valid}, 32'h1, "payload strobe");
		chk({31'h0, payload_bit}, {31'h0, ro}, "payload bit");
		u_chip_source.spacing = 0;
	endtask : t_payload

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_parallel();
		t_extended();
		t_seq16();
		t_gap(1'b1, t_on);
		t_gap(1'b0, t_off);
		chk(t_off - t_on, 32'h3, "fine gap length");
		t_payload(1'b0);
		t_payload(1'b1);
		wrap_up();
	end

	initial begin
		#500000;
		fail_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		wrap_up();
	end
endmodule : tb
